// [common/scan_seq_map.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes a 125 MHz system clock and a 32-bit word-aligned register bus
`ifndef SCAN_SEQ_MAP_SVH
`define SCAN_SEQ_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define QUEUE_DEPTH     8
`define RESULT_BITS     13
`define PACE_BITS       27
`define GAP_BITS        7
`define PAIRED_CHANNELS 4
`define PAIRED_SPANS    3

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADDR_CTRL       8'h00
`define ADDR_SCAN_START_PIN       8'h04
`define ADDR_PACE       8'h08
`define ADDR_QLEN       8'h0C
`define ADDR_STAT       8'h10
`define QUEUE_BASE_HI   3'h1

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_PAIRED     2
`define CTRL_BURST      3
`define CTRL_EXTPACE    4
`define CTRL_ARM        5
`define CTRL_RETRIG     6
`define SCAN_START_PIN_LEVEL      0
`define SCAN_START_PIN_INVERT     1
`define STAT_OVERRUN    2
`define QLEN_RESET      4'h1

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS   8
`define MAX_RATE_SPS    1000000
`define MIN_RATE_SPS    1
`define BURST_GAP_NS    1000
`define PACE_MIN_CYC    (1000000000 / (`CLK_PERIOD_NS * `MAX_RATE_SPS))
`define PACE_MAX_CYC    (1000000000 / (`CLK_PERIOD_NS * `MIN_RATE_SPS))
`define BURST_GAP_CYC   ((`BURST_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [common/scan_seq_pkg.sv]
// Types shared by the scan sequencer and its helpers
// Assumes the constant header is on the include path
`include "scan_seq_map.svh"

package scan_seq_pkg;

  typedef enum {ST_IDLE, ST_WAIT, ST_ISSUE, ST_BUSY, ST_GAP} seq_state_e;

  typedef struct packed {
    logic [1:0] span;
    logic [2:0] channel;
  } queue_entry_s;

  typedef struct packed {
    logic       paired;
    logic [1:0] span;
    logic [2:0] channel;
  } conv_req_s;

  typedef struct packed {
    logic [2:0]              channel;
    logic [1:0]              span;
    logic [`RESULT_BITS-1:0] data;
  } result_s;

endpackage

// [design/scan_sequencer.sv]
// Scan sequencer: channel queue, pacing, trigger and result path
// Assumes one AHB-Lite master, a converter that answers each start
// with one done pulse, and pins synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "scan_seq_map.svh"

module scan_sequencer
  import scan_seq_pkg::*;
#(
  parameter logic [`PACE_BITS-1:0] PACE_MAX_CYCLES = `PACE_BITS'(`PACE_MAX_CYC)
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pins
  input  wire logic        external_sample_clock_in,
  input  wire logic        scan_start_pin,
  output logic             sample_clock_out,
  // Converter
  output logic             convStart,
  output conv_req_s        convReq,
  input  wire logic        convDone,
  input  wire logic [`RESULT_BITS-1:0] convData,
  // Result stream
  output logic             resultValid,
  input  wire logic        resultReady,
  output result_s          resultData
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  queue_entry_s            queue [`QUEUE_DEPTH];
  logic [3:0]              queueLen;
  logic [2:0]              idx;
  logic                    pairedMode;
  logic                    burstEn;
  logic                    extPace;
  logic                    retrig;
  logic                    trigLevel;
  logic                    trigInvert;
  logic                    trigWritten;
  logic [`PACE_BITS-1:0]   paceDiv;
  logic [`PACE_BITS-1:0]   paceCnt;
  logic                    paceTick;
  logic                    extPrev;
  logic                    extRise;
  logic                    running;
  logic                    armed;
  logic                    trigFire;
  logic                    overrun;
  logic                    wrPend;
  logic [7:0]              wrAddr;
  logic [31:0]             next_rdata;
  logic                    ctrlWr;
  logic                    startWr;
  logic                    stopWr;
  logic                    armWr;
  seq_state_e              state;
  logic [`GAP_BITS-1:0]    gapCnt;
  logic [`GAP_BITS-1:0]    sinceStart;
  logic                    startNow;
  logic                    lastEntry;
  logic                    holdValid;
  result_s                 hold;
  logic                    bufInReady;
  conv_req_s               next_req;
  logic [`PACE_BITS-1:0]   wrPace;
  logic [3:0]              wrLen;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states: reads are registered at the address phase edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else if (hready) begin
      wrPend <= hsel && htrans[1] && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:5] == `QUEUE_BASE_HI) begin
      next_rdata[4:0] = queue[haddr[4:2]];
    end else begin
      case (haddr[7:0])
        `ADDR_CTRL: begin
          next_rdata[`CTRL_PAIRED]  = pairedMode;
          next_rdata[`CTRL_BURST]   = burstEn;
          next_rdata[`CTRL_EXTPACE] = extPace;
          next_rdata[`CTRL_RETRIG]  = retrig;
        end
        `ADDR_SCAN_START_PIN: begin
          next_rdata[`SCAN_START_PIN_LEVEL]  = trigLevel;
          next_rdata[`SCAN_START_PIN_INVERT] = trigInvert;
        end
        `ADDR_PACE: next_rdata[`PACE_BITS-1:0] = paceDiv;
        `ADDR_QLEN: next_rdata[3:0] = queueLen;
        `ADDR_STAT: next_rdata[6:0] = {idx, resultValid, overrun, armed, running};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  assign ctrlWr  = wrPend && (wrAddr == `ADDR_CTRL);
  assign startWr = ctrlWr && hwdata[`CTRL_START];
  assign stopWr  = ctrlWr && hwdata[`CTRL_STOP];
  assign armWr   = ctrlWr && hwdata[`CTRL_ARM];
  assign wrPace  = hwdata[`PACE_BITS-1:0];
  assign wrLen   = hwdata[3:0];

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // input mode and scan options
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pairedMode <= 1'b0;
      burstEn    <= 1'b0;
      extPace    <= 1'b0;
      retrig     <= 1'b0;
    end else if (ctrlWr) begin
      pairedMode <= hwdata[`CTRL_PAIRED];
      burstEn    <= hwdata[`CTRL_BURST];
      extPace    <= hwdata[`CTRL_EXTPACE];
      retrig     <= hwdata[`CTRL_RETRIG];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trigLevel   <= 1'b0;
      trigInvert  <= 1'b0;
      trigWritten <= 1'b0;
    end else if (wrPend && (wrAddr == `ADDR_SCAN_START_PIN)) begin
      trigLevel   <= hwdata[`SCAN_START_PIN_LEVEL];
      trigInvert  <= hwdata[`SCAN_START_PIN_INVERT];
      trigWritten <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      paceDiv <= `PACE_BITS'(`PACE_MIN_CYC);
    end else if (wrPend && (wrAddr == `ADDR_PACE)) begin
      if (wrPace < `PACE_BITS'(`PACE_MIN_CYC)) begin
        paceDiv <= `PACE_BITS'(`PACE_MIN_CYC);
      end else if (wrPace > PACE_MAX_CYCLES) begin
        paceDiv <= PACE_MAX_CYCLES;
      end else begin
        paceDiv <= wrPace;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      queueLen <= `QLEN_RESET;
    end else if (wrPend && (wrAddr == `ADDR_QLEN)) begin
      if (wrLen == 4'h0) begin
        queueLen <= 4'h1;
      end else if (wrLen > 4'(`QUEUE_DEPTH)) begin
        queueLen <= 4'(`QUEUE_DEPTH);
      end else begin
        queueLen <= wrLen;
      end
    end
  end

  generate
    for (genvar i = 0; i < `QUEUE_DEPTH; i++) begin : gQueue
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          queue[i] <= '0;
        end else if (wrPend && (wrAddr[7:5] == `QUEUE_BASE_HI) && (wrAddr[4:2] == 3'(i))) begin
          queue[i] <= hwdata[4:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Pacing and sample clock out
  // ****************************************************************
  assign extRise = external_sample_clock_in && !extPrev;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      paceCnt  <= '0;
      paceTick <= 1'b0;
      extPrev  <= 1'b0;
    end else begin
      extPrev <= external_sample_clock_in;
      if (extPace || !running || (paceCnt == (paceDiv - `PACE_BITS'(1)))) begin
        paceCnt <= '0;
      end else begin
        paceCnt <= paceCnt + `PACE_BITS'(1);
      end
      paceTick <= extPace ? extRise
                          : (running && (paceCnt == (paceDiv - `PACE_BITS'(1))));
    end
  end

  // clock out mirrors the pacing source
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_clock_out <= 1'b0;
    end else begin
      sample_clock_out <= extPace ? external_sample_clock_in
                                  : (running && (paceCnt < (paceDiv >> 1)));
    end
  end

  // ****************************************************************
  // Start, stop and trigger
  // ****************************************************************
  trigger_detect uTrig (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .scanStartPin (scan_start_pin),
    .levelMode    (trigLevel),
    .invert       (trigInvert),
    .armed        (armed && !running),
    .fire         (trigFire)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
    end else if (stopWr) begin
      running <= 1'b0;
    end else if (startWr || trigFire) begin
      running <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed <= 1'b0;
    end else if (stopWr) begin
      armed <= 1'b0;
    end else if (armWr) begin
      armed <= 1'b1;
    end else if (trigFire && !retrig) begin
      armed <= 1'b0;
    end
  end

  // A tick that finds the sequencer busy is dropped; set wins over clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overrun <= 1'b0;
    end else if (paceTick && running && (state != ST_WAIT) && (state != ST_IDLE)) begin
      overrun <= 1'b1;
    end else if (wrPend && (wrAddr == `ADDR_STAT) && hwdata[`STAT_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign lastEntry = ({1'b0, idx} == (queueLen - 4'h1));
  assign startNow  = running && !holdValid
                  && ((state == ST_ISSUE) || ((state == ST_GAP) && (gapCnt == '0)));

  // span and channel fitted to mode
  always_comb begin
    next_req.paired  = pairedMode;
    next_req.channel = queue[idx].channel;
    next_req.span    = queue[idx].span;
    if (pairedMode) begin
      next_req.channel = {1'b0, queue[idx].channel[1:0]};
      if (queue[idx].span == 2'(`PAIRED_SPANS)) begin
        next_req.span = 2'(`PAIRED_SPANS - 1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:  if (running) state <= ST_WAIT;
        ST_WAIT: begin
          if (!running) state <= ST_IDLE;
          else if (paceTick) state <= ST_ISSUE;
        end
        ST_ISSUE, ST_GAP: begin
          if (!running) state <= ST_IDLE;
          else if (startNow) state <= ST_BUSY;
        end
        ST_BUSY: begin
          if (convDone) begin
            if (!running) state <= ST_IDLE;
            else if (burstEn && !lastEntry) state <= ST_GAP;
            else state <= ST_WAIT;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gapCnt <= '0;
    end else if (startNow) begin
      gapCnt <= `GAP_BITS'(`BURST_GAP_CYC - 1);
    end else if (gapCnt != '0) begin
      gapCnt <= gapCnt - `GAP_BITS'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      convStart <= 1'b0;
      convReq   <= '0;
    end else begin
      convStart <= startNow;
      if (startNow) convReq <= next_req;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx <= 3'h0;
    end else if (startWr || trigFire) begin
      idx <= 3'h0;
    end else if ((state == ST_BUSY) && convDone) begin
      idx <= lastEntry ? 3'h0 : idx + 3'h1;
    end
  end

  // ****************************************************************
  // Result path
  // ****************************************************************
  // 13-bit result captured
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      holdValid <= 1'b0;
      hold      <= '0;
    end else if ((state == ST_BUSY) && convDone) begin
      holdValid <= 1'b1;
      hold      <= {convReq.channel, convReq.span, convData};
    end else if (bufInReady) begin
      holdValid <= 1'b0;
    end
  end

  two_entry_buffer uBuf (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inValid  (holdValid),
    .inReady  (bufInReady),
    .inData   (hold),
    .outValid (resultValid),
    .outReady (resultReady),
    .outData  (resultData)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sinceStart <= '0;
    end else if (convStart) begin
      sinceStart <= '0;
    end else if (sinceStart != '1) begin
      sinceStart <= sinceStart + `GAP_BITS'(1);
    end
  end

  queue_wrap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state == ST_BUSY) && convDone && lastEntry && !startWr && !trigFire |=> idx == 3'h0)
    else $error("queue did not wrap to entry zero");

  paired_chan_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    convStart && convReq.paired |-> convReq.channel < 3'(`PAIRED_CHANNELS))
    else $error("paired mode used a channel above three");

  paired_span_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    convStart && convReq.paired |-> convReq.span != 2'(`PAIRED_SPANS))
    else $error("paired mode used the fourth span");

  // Counter restarts the cycle after the start pulse, hence gap minus two
  burst_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    startNow && (state == ST_GAP) |-> sinceStart >= `GAP_BITS'(`BURST_GAP_CYC - 2))
    else $error("burst conversions closer than the gap");

  pace_limit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    paceDiv >= `PACE_BITS'(`PACE_MIN_CYC) && paceDiv <= PACE_MAX_CYCLES)
    else $error("pacing period outside its limits");

  ext_pace_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    extPace && extRise |=> paceTick)
    else $error("external edge gave no pacing tick");

  scan_start_pin_default_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !trigWritten |-> !trigLevel && !trigInvert)
    else $error("trigger setup left rising edge before any write");

  rearm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    trigFire && retrig && !stopWr |=> armed && running)
    else $error("retrigger did not stay armed");

  clk_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    extPace |=> sample_clock_out == $past(external_sample_clock_in))
    else $error("clock out does not repeat the external clock");

  start_cmd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    startWr && !stopWr |=> running ##1 (state == ST_WAIT))
    else $error("start command did not begin the scan");

  no_loss_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    holdValid && !bufInReady |=> holdValid && $stable(hold))
    else $error("result lost while the buffer was full");

endmodule

`default_nettype wire

// [design/trigger_detect.sv]
// External start pin qualifier: edge or level, either polarity
// Assumes the pin is already synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none

module trigger_detect
  import scan_seq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Pin and setup
  input  wire logic scanStartPin,
  input  wire logic levelMode,
  input  wire logic invert,
  input  wire logic armed,
  // Result
  output logic      fire
);

  logic active;
  logic prevActive;

  assign active = scanStartPin ^ invert;

  // Reset high so a pin that already sits active does not fire at once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prevActive <= 1'b1;
    end else begin
      prevActive <= active;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fire <= 1'b0;
    end else begin
      fire <= armed && (levelMode ? active : (active && !prevActive));
    end
  end

  edge_single_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    fire && !levelMode && $stable(levelMode) |=> !fire)
    else $error("edge trigger fired twice in a row");

endmodule

`default_nettype wire

// [design/two_entry_buffer.sv]
// Two-entry result buffer with valid and ready on both sides
// Assumes the drain side may hold ready low for any time
`timescale 1ns/1ns
`default_nettype none

module two_entry_buffer
  import scan_seq_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_sys,
  input  wire logic    resetn,
  // Fill side
  input  wire logic    inValid,
  output logic         inReady,
  input  wire result_s inData,
  // Drain side
  output logic         outValid,
  input  wire logic    outReady,
  output result_s      outData
);

  result_s slot [2];
  logic    tailValid;
  logic    pop;
  logic    push;

  assign inReady  = !tailValid;
  assign pop      = outValid && outReady;
  assign push     = inValid && inReady;
  assign outData  = slot[0];

  // Slot 0 is the head that drives the port, slot 1 the overflow
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slot[0]   <= '0;
      slot[1]   <= '0;
      outValid  <= 1'b0;
      tailValid <= 1'b0;
    end else if (!outValid || pop) begin
      if (tailValid) begin
        slot[0]   <= slot[1];
        outValid  <= 1'b1;
        tailValid <= 1'b0;
      end else begin
        slot[0]  <= inData;
        outValid <= push;
      end
    end else if (push) begin
      slot[1]   <= inData;
      tailValid <= 1'b1;
    end
  end

  keep_word_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("buffered word changed while stalled");

endmodule

`default_nettype wire

// [verif/conv_model.sv]
// Converter stand-in: one result per start, after a given delay
// Assumes starts come one at a time from the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "scan_seq_map.svh"
module conv_model
  import scan_seq_pkg::*;
(
  // Clock and request
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        convStart,
  input  wire conv_req_s   convReq,
  input  wire logic [7:0]  delay,
  // Result
  output logic             convDone,
  output logic [`RESULT_BITS-1:0] convData
);
  logic [7:0] left;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left <= 8'h00;
      convDone <= 1'b0;
      convData <= '1;
    end else begin
      convDone <= 1'b0;
      // Stale data toggles so it never passes for a result
      convData <= ~convData;
      if (convStart) begin
        left <= delay + 8'h01;
      end else if (left == 8'h01) begin
        left <= 8'h00;
        convDone <= 1'b1;
        convData <= `RESULT_BITS'(convReq);
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/scan_sequencer_tb.sv]
// Bench for the scan sequencer: bus, pacing, burst, trigger
// Assumes the converter model and a random host ready
`timescale 1ns/1ns
`default_nettype none
module scan_sequencer_tb import scan_seq_pkg::*; ;
  logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
  logic extClk, startPin, sclkOut, convStart, convDone;
  logic resultValid, resultReady;
  wire logic hready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [12:0] convData;
  logic [7:0] dly;
  logic [7:0] lf = 8'h3E;
  conv_req_s convReq;
  result_s resultData;
  result_s expQ[$];
  int n_fail = 0;
  int n_tests = 0;
  int i, k;
  assign hready = hreadyout;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Small pace limit keeps the run short
  scan_sequencer #(.PACE_MAX_CYCLES(27'h3E8)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .external_sample_clock_in(extClk), .scan_start_pin(startPin),
    .sample_clock_out(sclkOut), .convStart(convStart), .convReq(convReq),
    .convDone(convDone), .convData(convData), .resultValid(resultValid),
    .resultReady(resultReady), .resultData(resultData));
  conv_model conv (.clk_sys(clk_sys), .resetn(resetn), .convStart(convStart),
    .convReq(convReq), .delay(dly), .convDone(convDone), .convData(convData));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always @(posedge clk_sys) begin
    lf <= nxt(lf);
    resultReady <= lf[0] | lf[1];
    dly <= lf & 8'h1F;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_res(input result_s e, input result_s g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR result exp %h got %h", e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task note(input logic p, input logic [1:0] s, input logic [2:0] c);
    expQ.push_back({c, s, 13'({p, s, c})});
  endtask
  task run_out(input string nm);
    int j;
    for (j = 0; j < 3000 && expQ.size() > 0; j++) @(posedge clk_sys);
    chk("pending", 0, expQ.size());
    bus(1, 8'h00, 32'h2);
    repeat (300) @(posedge clk_sys);
    $display("%s done", nm);
  endtask
  always @(posedge clk_sys) begin
    if (resultValid === 1'b1 && resultReady === 1'b1 && expQ.size() > 0) begin
      chk_res(expQ.pop_front(), resultData);
    end
  end
  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    {resetn, hsel, hwrite, extClk, startPin} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    bus(0, 8'h04, 0);
    chk("scan_start_pin", 0, r);
    chk("resp", 0, hresp);
    bus(0, 8'hFC, 0);
    chk("unmapped", 0, r);
    bus(1, 8'h08, 32'h07FF_FFFF);
    bus(0, 8'h08, 0);
    chk("pace max", 32'h3E8, r);
    bus(1, 8'h08, 1);
    bus(0, 8'h08, 0);
    chk("pace", 32'h7D, r);
    bus(1, 8'h0C, 9);
    bus(0, 8'h0C, 0);
    chk("qlen", 8, r);
    for (i = 0; i < 8; i++) bus(1, 8'(32 + 4 * i), 32'({i[1:0], 3'(7 - i)}));
    $display("registers done");
    for (k = 0; k < 10; k++) note(0, k[1:0], 3'(7 - k % 8));
    bus(1, 8'h00, 32'h1);
    run_out("scan");
    // paired spans, span 3 sent as 2
    bus(1, 8'h0C, 4);
    for (k = 0; k < 8; k++) note(1, (k[1:0] == 2'h3) ? 2'h2 : k[1:0], 3'(3 - k % 4));
    bus(1, 8'h00, 32'h1D);
    for (k = 0; k < 2; k++) begin
      extClk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("clock out", 1, sclkOut);
      @(posedge clk_sys);
      extClk <= 1'b0;
      repeat (900) @(posedge clk_sys);
    end
    run_out("burst");
    bus(1, 8'h0C, 1);
    for (k = 0; k < 4; k++) begin
      startPin <= k[1];
      bus(1, 8'h04, k);
      bus(1, 8'h00, {25'h0, k[0], 6'h20});
      repeat (5) @(posedge clk_sys);
      bus(0, 8'h10, 0);
      chk("idle", 0, r[0]);
      startPin <= ~k[1];
      note(0, 2'h0, 3'h7);
      repeat (5) @(posedge clk_sys);
      bus(0, 8'h10, 0);
      chk("running", 1, r[0]);
      chk("rearm", k[0], r[1]);
      run_out("trigger");
    end
    wrap_up();
  end
endmodule
`default_nettype wire
